// file: inc/fpr_pkg.sv
package fpr_pkg;
  // geometry
  localparam int unsigned PAGE_BYTES    = 256;
  localparam int unsigned PAGE_COUNT    = 512;
  localparam int unsigned REGION_PAGES  = 64;
  localparam int unsigned REGION_COUNT  = 8;
  localparam int unsigned WORDS_PER_PG  = PAGE_BYTES / 4;
  localparam int unsigned PAGE_W        = 9;
  localparam int unsigned WIDX_W        = 6;
  localparam int unsigned REGION_LSB    = 6;
  // system address map
  localparam logic [31:0] SRAM_BASE     = 32'h0020_0000;
  localparam logic [31:0] FLASH_BASE    = 32'h0010_0000;
  localparam logic [31:0] ZERO_BASE     = 32'h0000_0000;
  localparam logic [31:0] AREA_MASK     = 32'hFFF0_0000;
  // register byte offsets
  localparam logic [5:0] OFS_MODE       = 6'h00;
  localparam logic [5:0] OFS_CMD        = 6'h04;
  localparam logic [5:0] OFS_STATUS     = 6'h08;
  localparam logic [5:0] OFS_LOCKS      = 6'h0C;
  localparam logic [5:0] OFS_NVBITS     = 6'h10;
  localparam logic [5:0] OFS_BUFWORD    = 6'h14;
  localparam logic [5:0] OFS_IRQEN      = 6'h18;
  localparam logic [5:0] OFS_REMAP      = 6'h1C;
  localparam logic [5:0] OFS_ID         = 6'h20;
  // command register fields
  localparam int unsigned CMD_KEY_LSB   = 24;
  localparam logic [7:0]  CMD_KEY       = 8'h5A;
  localparam int unsigned CMD_ARG_LSB   = 8;
  // status bits
  localparam int unsigned ST_READY      = 0;
  localparam int unsigned ST_LOCKERR    = 1;
  localparam int unsigned ST_CMDERR     = 2;
  localparam int unsigned ST_SECURE     = 3;
  // reset values
  localparam logic [7:0]  CAL_BITS_RST  = 8'h00;
  localparam logic [31:0] ID_VALUE      = 32'h0000_1234; // arbitrary value
  // command timing
  localparam int unsigned PROG_NS       = 4000000;
  localparam int unsigned ERASE_NS      = 10000000;
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned PROG_CYC      = PROG_NS / CLK_NS;
  localparam int unsigned ERASE_CYC     = ERASE_NS / CLK_NS;

  typedef enum logic [7:0] {
    FPR_OP_NONE     = 8'h00,
    FPR_OP_PROG     = 8'h01,
    FPR_OP_PGERASE  = 8'h02,
    FPR_OP_SETLOCK  = 8'h03,
    FPR_OP_CLRLOCK  = 8'h04,
    FPR_OP_FULLERA  = 8'h05,
    FPR_OP_SETNV    = 8'h06,
    FPR_OP_CLRNV    = 8'h07,
    FPR_OP_SETSEC   = 8'h08
  } fpr_op_e;

  typedef enum logic [2:0] {
    FPR_ST_IDLE = 3'b001,
    FPR_ST_BUSY = 3'b010,
    FPR_ST_DONE = 3'b100
  } fpr_state_e;

  // system access request and answer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpr_sysreq_s;

  typedef struct packed {
    logic        sel_flash;
    logic        sel_sram;
    logic        sel_none;
    logic [31:0] offset;
  } fpr_decode_s;

  // nonvolatile state seen by the testbench outside
  typedef struct packed {
    logic [REGION_COUNT-1:0] locks;
    logic                    secure;
    logic [1:0]              gp_bits;
  } fpr_nvstate_s;
endpackage : fpr_pkg

// file: sim/fpr_array_model.sv
module fpr_array_model (
  // clock
  input  wire logic        ref_clk,
  // array side
  input  wire logic        array_standby,
  input  wire logic        array_prog,
  input  wire logic [31:0] pgbuf_rdata,
  output logic      [31:0] array_rdata,
  output logic      [5:0]  pgbuf_raddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // one page only, keeps the model small
  logic [31:0] mem [0:63];
  logic [31:0] last_q;
  initial begin
    pgbuf_raddr = 6'h00;
    last_q = 32'h0000_0000;
  end
  always @(posedge ref_clk) begin
    if (array_prog) begin
      mem[pgbuf_raddr] <= pgbuf_rdata;
    end
    pgbuf_raddr <= array_prog ? pgbuf_raddr + 6'h01 : 6'h00;
    if (!array_standby) begin
      last_q <= mem[pgbuf_raddr];
    end
  end
  // idle array shows the last word read, inverted
  assign array_rdata = array_standby ? ~last_q : last_q;
endmodule : fpr_array_model

// file: sim/testbench.sv
module testbench;
  import fpr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address, pgbuf_raddr;
  logic [31:0] avs_writedata, avs_readdata, array_rdata, pgbuf_rdata;
  logic [31:0] pf_word0, pf_word1, off, w0, rd_val;
  logic [3:0] avs_byteenable;
  fpr_sysreq_s sys_req;
  fpr_decode_s sys_decode;
  fpr_nvstate_s nv_state;
  logic sys_from_debug, sys_refused, array_standby, pf_hit, array_prog;
  logic array_erase, erase_pin, test_mode_pin, ctrl_irq;
  logic strap_pin_first, strap_pin_second, strap_pin_third;
  logic brownout_detector_en, brownout_reset_en, fast_programming_port_en;
  logic [8:0] array_page;
  logic [7:0] cal_bits_in;
  logic [2:0] rg;
  logic [1:0] wait_states;
  int n_errors, check_count, k;
  int seed = 32'h0000_623d;
  fpr_flash_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(20)) dut_u (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sys_req,
    .sys_from_debug, .sys_decode, .sys_refused, .array_rdata,
    .array_standby, .pf_word0, .pf_word1, .pf_hit, .pgbuf_rdata,
    .pgbuf_raddr, .array_prog, .array_erase, .array_page, .erase_pin,
    .test_mode_pin, .strap_pin_first, .strap_pin_second, .strap_pin_third,
    .cal_bits_in, .nv_state, .brownout_detector_en, .brownout_reset_en,
    .fast_programming_port_en, .ctrl_irq, .wait_states);
  fpr_array_model array_u (.ref_clk, .array_standby, .array_prog,
    .pgbuf_rdata, .array_rdata, .pgbuf_raddr);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (!avs_waitrequest) break;
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  // fixed wait: command length is set by the parameters above
  task automatic cmd(input logic [7:0] op, input logic [8:0] arg);
    bus(1'b1, OFS_CMD, {CMD_KEY, 7'h00, arg, op});
    repeat (40) @(posedge ref_clk);
  endtask : cmd
  task automatic dec(input logic [31:0] a, input logic [2:0] exp);
    sys_req <= '{1'b1, 1'b0, a, 32'h0000_0000};
    @(negedge ref_clk);
    chk("decode", {29'h0, exp}, {29'h0, sys_decode.sel_flash,
        sys_decode.sel_sram, sys_decode.sel_none});
    chk("standby", {31'h0, !exp[2]}, {31'h0, array_standby});
    @(posedge ref_clk);
  endtask : dec
  // scaled pulse; the real pin needs far longer
  task automatic erase_pulse;
    erase_pin <= 1'b1;
    repeat (12) @(posedge ref_clk);
    erase_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : erase_pulse
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
  initial begin
    {avs_read, avs_write, sys_from_debug, erase_pin} = 4'h0;
    {test_mode_pin, strap_pin_first, strap_pin_second} = 3'h0;
    strap_pin_third = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    sys_req = '0;
    cal_bits_in = 8'($random(seed));
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    off = 32'($random(seed)) & 32'h000F_FFFC;
    dec(ZERO_BASE + off, 3'b100);
    dec(FLASH_BASE + off, 3'b100);
    chk("prefetch hit", 1, {31'h0, pf_hit});
    dec(SRAM_BASE + off, 3'b010);
    dec(32'h0040_0000, 3'b001);
    bus(1'b1, OFS_REMAP, 32'h0000_0001);
    dec(ZERO_BASE + off, 3'b010);
    dec(FLASH_BASE + off, 3'b100);
    sys_req.valid <= 1'b0;
    @(negedge ref_clk);
    chk("idle standby", 1, {31'h0, array_standby});
    @(posedge ref_clk);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, OFS_MODE, 32'(k));
      chk("wait_states", k, {30'h0, wait_states});
    end
    w0 = $random(seed);
    for (k = 0; k < 64; k++) bus(1'b1, OFS_BUFWORD, w0 + 32'(k));
    cmd(FPR_OP_PROG, 9'($random(seed)));
    chk("page word", w0, array_u.mem[0]);
    bus(1'b1, OFS_IRQEN, 32'h0000_0002);
    for (k = 0; k < 4; k++) begin
      rg = 3'($random(seed)) | 3'h1;
      cmd(FPR_OP_SETLOCK, {6'h00, rg});
      chk("lock", 1, {31'h0, nv_state.locks[rg]});
      cmd(k[0] ? FPR_OP_PGERASE : FPR_OP_PROG, {rg - 3'h1, 6'h3F});
      chk("irq free", 0, {31'h0, ctrl_irq});
      cmd(k[0] ? FPR_OP_PGERASE : FPR_OP_PROG, {rg, 6'h00});
      chk("irq locked", 1, {31'h0, ctrl_irq});
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("status", 32'((1 << ST_READY) | (1 << ST_LOCKERR)),
          rd_val);
      chk("irq cleared", 0, {31'h0, ctrl_irq});
      bus(1'b0, 6'h3C, 32'h0000_0000);
      cmd(FPR_OP_CLRLOCK, {6'h00, rg});
      chk("unlock", 0, {31'h0, nv_state.locks[rg]});
    end
    for (k = 0; k < 2; k++) begin
      cmd(FPR_OP_SETNV, 9'(k));
      chk("gp set", 1 << k, {30'h0, brownout_reset_en,
          brownout_detector_en});
      cmd(FPR_OP_CLRNV, 9'(k));
      chk("gp clr", 0, {30'h0, nv_state.gp_bits});
    end
    cmd(FPR_OP_SETNV, 9'h000);
    cmd(FPR_OP_SETNV, 9'h001);
    cmd(FPR_OP_SETLOCK, 9'h007);
    erase_pulse();
    chk("erase pin", 0, {20'h0, nv_state.locks, nv_state.gp_bits,
        brownout_detector_en, brownout_reset_en});
    bus(1'b0, OFS_NVBITS, 32'h0000_0000);
    chk("cal bits", {16'h0, cal_bits_in, 8'h00}, rd_val);
    // full erase uses up the pin mark, so security starts clean
    cmd(FPR_OP_FULLERA, 9'h000);
    cmd(FPR_OP_SETSEC, 9'h000);
    chk("secure", 1, {31'h0, nv_state.secure});
    sys_from_debug <= 1'b1;
    dec(FLASH_BASE, 3'b000);
    chk("debug refused", 1, {31'h0, sys_refused});
    sys_from_debug <= 1'b0;
    dec(FLASH_BASE, 3'b100);
    chk("cpu allowed", 0, {31'h0, sys_refused});
    {test_mode_pin, strap_pin_first, strap_pin_second} <= 3'h7;
    repeat (6) @(posedge ref_clk);
    chk("port refused", 1, {31'h0, sys_refused});
    {test_mode_pin, strap_pin_first, strap_pin_second} <= 3'h0;
    repeat (6) @(posedge ref_clk);
    cmd(FPR_OP_FULLERA, 9'h000);
    chk("secure kept", 1, {31'h0, nv_state.secure});
    erase_pulse();
    cmd(FPR_OP_FULLERA, 9'h000);
    chk("secure clr", 0, {31'h0, nv_state.secure});
    for (k = 0; k < 16; k++) begin
      {test_mode_pin, strap_pin_first, strap_pin_second,
       strap_pin_third} <= 4'(k);
      repeat (6) @(posedge ref_clk);
      chk("fast port", {31'h0, k == 14},
          {31'h0, fast_programming_port_en});
    end
    close_out();
  end
endmodule : testbench

// file: src/fpr_flash_protect.sv
// Function
// RULE_01: sram decoded at 0x0020_0000, and also at zero once remapped
// RULE_02: flash always at 0x0010_0000, aliased at zero before remap
// RULE_03: array is 512 pages of 256 bytes in 32-bit words
// RULE_04: 256-byte page buffer filled by 32-bit writes before program
// RULE_05: array put in standby whenever no access is in progress
// RULE_06: registers give wait states, commands, status and irq enables
// RULE_07: dual 32-bit prefetch words serve sequential 16-bit fetches
// RULE_08: eight lock bits, each covering 64 pages (16 Kbytes)
// RULE_09: erase or program into a locked region aborts and interrupts
// RULE_10: set-lock sets region lock bit, clear-lock clears it
// RULE_11: erase pin clears every region lock bit
// RULE_12: secure bit refuses debug-port and programming-port access
// RULE_13: secure set only by command; cleared by erase pin plus erase
// RULE_14: party outside holds erase pin above 50 ms
// RULE_15: two nonvolatile bits, set and cleared by command, persistent; rst_b clears them here
// RULE_16: bit 0 enables brownout detector; erase pin clears it
// RULE_17: bit 1 enables brownout reset; erase pin clears it
// RULE_18: eight calibration bits read-only, untouched by erase pin
// RULE_19: programmer holds test pin and two straps high, third low
// RULE_20: programming port accepts read, program, erase, lock commands; here only fast_programming_port_en is driven, with no command path
// RULE_21: remap flag cleared by reset, set by remap command
//
// The register offsets and register access over Avalon-MM were decided locally.
module fpr_flash_protect #(
  parameter int unsigned PROG_CYCLES  = fpr_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYCLES = fpr_pkg::ERASE_CYC
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // avalon-mm register slave
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // system access decode
  input  wire fpr_pkg::fpr_sysreq_s sys_req,
  input  wire logic                sys_from_debug,
  output fpr_pkg::fpr_decode_s     sys_decode,
  output logic                     sys_refused,
  // flash array side
  input  wire logic [31:0]         array_rdata,
  output logic                     array_standby,
  output logic [31:0]              pf_word0,
  output logic [31:0]              pf_word1,
  output logic                     pf_hit,
  // page buffer toward array during program
  output logic [31:0]              pgbuf_rdata,
  input  wire logic [5:0]          pgbuf_raddr,
  output logic                     array_prog,
  output logic                     array_erase,
  output logic [8:0]               array_page,
  // pins
  input  wire logic                erase_pin,
  input  wire logic                test_mode_pin,
  input  wire logic                strap_pin_first,
  input  wire logic                strap_pin_second,
  input  wire logic                strap_pin_third,
  input  wire logic [7:0]          cal_bits_in,
  // status outputs
  output fpr_pkg::fpr_nvstate_s    nv_state,
  output logic                     brownout_detector_en,
  output logic                     brownout_reset_en,
  output logic                     fast_programming_port_en,
  output logic                     ctrl_irq,
  output logic [1:0]               wait_states
);
  import fpr_pkg::*;

  // RULE_08 eight regions of 64 pages
  function automatic logic [2:0] region_of(input logic [8:0] page);
    region_of = page[8:REGION_LSB];
  endfunction : region_of

  function automatic logic in_area(input logic [31:0] a,
                                   input logic [31:0] base);
    in_area = (a & AREA_MASK) == base;
  endfunction : in_area

  // pin synchronisers, three stages, change once stages two and three agree
  logic [2:0] er_sync_reg, er_sync_next;
  logic [2:0] pm_sync_reg, pm_sync_next;
  logic       er_lvl_reg, er_lvl_next;
  logic       pm_lvl_reg, pm_lvl_next;
  logic       pm_raw;
  always_comb begin
    // RULE_19 strap decode
    pm_raw = test_mode_pin & strap_pin_first & strap_pin_second
           & ~strap_pin_third;
    er_sync_next = {er_sync_reg[1:0], erase_pin};
    pm_sync_next = {pm_sync_reg[1:0], pm_raw};
    er_lvl_next  = (er_sync_reg[1] == er_sync_reg[2]) ? er_sync_reg[2]
                                                      : er_lvl_reg;
    pm_lvl_next  = (pm_sync_reg[1] == pm_sync_reg[2]) ? pm_sync_reg[2]
                                                      : pm_lvl_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      er_sync_reg <= 3'h0;
      pm_sync_reg <= 3'h0;
      er_lvl_reg  <= 1'b0;
      pm_lvl_reg  <= 1'b0;
    end else begin
      er_sync_reg <= er_sync_next;
      pm_sync_reg <= pm_sync_next;
      er_lvl_reg  <= er_lvl_next;
      pm_lvl_reg  <= pm_lvl_next;
    end
  end

  // control and nonvolatile state
  // nv bits do not model persistence: rst_b clears locks, secure and
  // general-purpose bits to zero like every other register except st_reg, pfa_reg and pgbuf
  logic [7:0]  lock_reg, lock_next;
  logic        sec_reg, sec_next;
  logic [1:0]  gp_reg, gp_next;
  logic [7:0]  cal_reg, cal_next;
  logic        cal_cap_reg, cal_cap_next;
  logic        remap_reg, remap_next;
  logic [1:0]  ws_reg, ws_next;
  logic [1:0]  irqen_reg, irqen_next;
  logic        done_reg, done_next;
  logic        lockerr_reg, lockerr_next;
  logic        cmderr_reg, cmderr_next;
  logic        ers_seen_reg, ers_seen_next;
  fpr_state_e  st_reg, st_next;
  fpr_op_e     op_reg, op_next;
  logic [8:0]  page_reg, page_next;
  logic [23:0] cnt_reg, cnt_next;
  logic [5:0]  widx_reg, widx_next;
  logic [31:0] pgbuf [WORDS_PER_PG];
  logic [31:0] rd_reg, rd_next;
  logic        ack_reg, ack_next;

  logic        acc;
  logic        req_first;
  logic        wr_cmd;
  fpr_op_e     cmd_op;
  logic [8:0]  cmd_arg;
  logic        buf_wr;
  // wait cycle first; the transfer lands on the edge that sees it low
  assign req_first = (avs_read | avs_write) & ~ack_reg;
  assign acc       = (avs_read | avs_write) & ack_reg;
  assign wr_cmd = acc & avs_write & (avs_address == OFS_CMD)
                & (avs_writedata[31:CMD_KEY_LSB] == CMD_KEY);
  assign cmd_op  = fpr_op_e'(avs_writedata[7:0]);
  assign cmd_arg = avs_writedata[CMD_ARG_LSB +: PAGE_W];
  // RULE_04 buffer written a word at a time
  assign buf_wr = acc & avs_write & (avs_address == OFS_BUFWORD)
                & (st_reg != FPR_ST_BUSY);

  always_comb begin
    lock_next    = lock_reg;
    sec_next     = sec_reg;
    gp_next      = gp_reg;
    cal_next     = cal_reg;
    cal_cap_next = 1'b1;
    remap_next   = remap_reg;
    ws_next      = ws_reg;
    irqen_next   = irqen_reg;
    done_next    = done_reg;
    lockerr_next = lockerr_reg;
    cmderr_next  = cmderr_reg;
    ers_seen_next = ers_seen_reg | er_lvl_reg;
    st_next      = st_reg;
    op_next      = op_reg;
    page_next    = page_reg;
    cnt_next     = cnt_reg;
    widx_next    = widx_reg;
    rd_next      = 32'h0000_0000;
    ack_next     = req_first;
    // RULE_18 calibration captured once after reset, never written
    if (!cal_cap_reg) begin
      cal_next = cal_bits_in;
    end
    // RULE_06 readback, fixed in the wait cycle
    if (req_first && avs_read) begin
      unique case (avs_address)
        OFS_STATUS: begin
          rd_next[ST_READY]   = done_reg;
          rd_next[ST_LOCKERR] = lockerr_reg;
          rd_next[ST_CMDERR]  = cmderr_reg;
          rd_next[ST_SECURE]  = sec_reg;
        end
        OFS_LOCKS:  rd_next = {24'h0, lock_reg};
        OFS_NVBITS: rd_next = {16'h0, cal_reg, 6'h0, gp_reg};
        OFS_ID:     rd_next = ID_VALUE;
        default:    ;
      endcase
    end
    // status read clears only what it reported; set below wins
    if (acc && avs_read && avs_address == OFS_STATUS) begin
      lockerr_next = lockerr_reg & ~rd_reg[ST_LOCKERR];
      cmderr_next  = cmderr_reg & ~rd_reg[ST_CMDERR];
      done_next    = done_reg & ~rd_reg[ST_READY];
    end
    if (acc && avs_write) begin
      unique case (avs_address)
        // RULE_06 wait states and irq enables
        OFS_MODE:    ws_next = avs_writedata[1:0];
        OFS_IRQEN:   irqen_next = avs_writedata[1:0];
        // RULE_21 remap command
        OFS_REMAP:   remap_next = remap_reg | avs_writedata[0];
        OFS_BUFWORD: widx_next = buf_wr ? 6'(widx_reg + 6'h01) : widx_reg;
        default:     ;
      endcase
    end
    unique case (st_reg)
      FPR_ST_IDLE, FPR_ST_DONE: begin
        if (wr_cmd) begin
          st_next   = FPR_ST_DONE;
          op_next   = cmd_op;
          page_next = cmd_arg;
          done_next = 1'b1;
          unique case (cmd_op)
            FPR_OP_PROG, FPR_OP_PGERASE: begin
              // RULE_09 locked region aborts
              if (lock_reg[region_of(cmd_arg)]) begin
                lockerr_next = 1'b1;
              end else begin
                st_next   = FPR_ST_BUSY;
                done_next = 1'b0;
                cnt_next  = 24'(PROG_CYCLES);
              end
            end
            FPR_OP_FULLERA: begin
              if (|lock_reg) begin
                lockerr_next = 1'b1;
              end else begin
                st_next   = FPR_ST_BUSY;
                done_next = 1'b0;
                cnt_next  = 24'(ERASE_CYCLES);
              end
            end
            // RULE_10 lock set and clear
            FPR_OP_SETLOCK: lock_next[cmd_arg[2:0]] = 1'b1;
            FPR_OP_CLRLOCK: lock_next[cmd_arg[2:0]] = 1'b0;
            // RULE_15 general-purpose bits
            FPR_OP_SETNV:   gp_next[cmd_arg[0]] = 1'b1;
            FPR_OP_CLRNV:   gp_next[cmd_arg[0]] = 1'b0;
            // RULE_13 security set only here
            FPR_OP_SETSEC:  sec_next = 1'b1;
            default:        cmderr_next = 1'b1;
          endcase
        end else if (wr_cmd == 1'b0 && acc && avs_write
                     && avs_address == OFS_CMD) begin
          cmderr_next = 1'b1;
        end
      end
      FPR_ST_BUSY: begin
        if (wr_cmd) begin
          cmderr_next = 1'b1;
        end
        cnt_next = 24'(cnt_reg - 24'h00_0001);
        if (cnt_reg <= 24'h00_0001) begin
          st_next   = FPR_ST_DONE;
          done_next = 1'b1;
          if (op_reg == FPR_OP_PROG) begin
            widx_next = 6'h00;
          end
          // RULE_13 erase pin plus full erase drops security
          if (op_reg == FPR_OP_FULLERA && (ers_seen_reg | er_lvl_reg)) begin
            sec_next      = 1'b0;
            ers_seen_next = 1'b0;
          end
        end
      end
      default: st_next = FPR_ST_IDLE;
    endcase
    // RULE_11 erase pin unlocks everything
    if (er_lvl_reg) begin
      lock_next = 8'h00;
      // RULE_16 RULE_17 brownout bits cleared
      gp_next   = 2'b00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lock_reg     <= 8'h00;
      sec_reg      <= 1'b0;
      gp_reg       <= 2'b00;
      cal_reg      <= CAL_BITS_RST;
      cal_cap_reg  <= 1'b0;
      remap_reg    <= 1'b0;
      ws_reg       <= 2'b00;
      irqen_reg    <= 2'b00;
      done_reg     <= 1'b0;
      lockerr_reg  <= 1'b0;
      cmderr_reg   <= 1'b0;
      ers_seen_reg <= 1'b0;
      st_reg       <= FPR_ST_IDLE;
      op_reg       <= FPR_OP_NONE;
      page_reg     <= 9'h000;
      cnt_reg      <= 24'h00_0000;
      widx_reg     <= 6'h00;
      rd_reg       <= 32'h0000_0000;
      ack_reg      <= 1'b0;
    end else begin
      lock_reg     <= lock_next;
      sec_reg      <= sec_next;
      gp_reg       <= gp_next;
      cal_reg      <= cal_next;
      cal_cap_reg  <= cal_cap_next;
      remap_reg    <= remap_next;
      ws_reg       <= ws_next;
      irqen_reg    <= irqen_next;
      done_reg     <= done_next;
      lockerr_reg  <= lockerr_next;
      cmderr_reg   <= cmderr_next;
      ers_seen_reg <= ers_seen_next;
      st_reg       <= st_next;
      op_reg       <= op_next;
      page_reg     <= page_next;
      cnt_reg      <= cnt_next;
      widx_reg     <= widx_next;
      rd_reg       <= rd_next;
      ack_reg      <= ack_next;
    end
  end

  // memory array, no reset needed
  always_ff @(posedge ref_clk) begin
    if (buf_wr) begin
      pgbuf[widx_reg] <= avs_writedata;
    end
  end
  assign pgbuf_rdata = pgbuf[pgbuf_raddr];

  // register read mux, answered the cycle after the request
  always_comb begin
    avs_readdata = 32'h0000_0000;
    if (ack_reg) begin
      avs_readdata = rd_reg;
    end
  end
  assign avs_waitrequest = req_first;

  // system address decode
  logic sel_zero, sel_fl, sel_sr;
  assign sel_zero = in_area(sys_req.addr, ZERO_BASE);
  // RULE_02 flash window and boot alias
  assign sel_fl = in_area(sys_req.addr, FLASH_BASE)
                | (sel_zero & ~remap_reg);
  // RULE_01 sram window, at zero after remap
  assign sel_sr = in_area(sys_req.addr, SRAM_BASE)
                | (sel_zero & remap_reg);
  // RULE_12 secure refuses debug and programming port
  assign sys_refused = sys_req.valid & sel_fl & sec_reg
                     & (sys_from_debug | pm_lvl_reg);
  always_comb begin
    sys_decode.sel_flash = sys_req.valid & sel_fl & ~sys_refused;
    sys_decode.sel_sram  = sys_req.valid & sel_sr;
    sys_decode.sel_none  = sys_req.valid & ~sel_fl & ~sel_sr;
    // RULE_03 offset within 128 Kbyte array
    sys_decode.offset    = {15'h0000, sys_req.addr[16:0]};
  end

  // RULE_07 dual prefetch words on sequential fetches
  logic [31:0] pf0_reg, pf0_next, pf1_reg, pf1_next;
  logic [14:0] pfa_reg, pfa_next;
  logic        pf_hit_c;
  always_comb begin
    pf_hit_c = sys_decode.sel_flash & ~sys_req.write
             & (sys_req.addr[16:2] == pfa_reg);
    pf0_next = pf0_reg;
    pf1_next = pf1_reg;
    pfa_next = pfa_reg;
    if (sys_decode.sel_flash && !sys_req.write && !pf_hit_c) begin
      pf1_next = pf0_reg;
      pf0_next = array_rdata;
      pfa_next = sys_req.addr[16:2];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pf0_reg <= 32'h0000_0000;
      pf1_reg <= 32'h0000_0000;
      pfa_reg <= 15'h7FFF;
    end else begin
      pf0_reg <= pf0_next;
      pf1_reg <= pf1_next;
      pfa_reg <= pfa_next;
    end
  end
  assign pf_word0 = pf0_reg;
  assign pf_word1 = pf1_reg;
  assign pf_hit   = pf_hit_c;

  // RULE_05 standby when nothing touches the array
  assign array_standby = ~sys_decode.sel_flash & (st_reg != FPR_ST_BUSY);
  assign array_prog  = (st_reg == FPR_ST_BUSY) & (op_reg == FPR_OP_PROG);
  assign array_erase = (st_reg == FPR_ST_BUSY) & (op_reg != FPR_OP_PROG);
  assign array_page  = page_reg;

  assign nv_state.locks   = lock_reg;
  assign nv_state.secure  = sec_reg;
  assign nv_state.gp_bits = gp_reg;
  // RULE_16 brownout detector enable
  assign brownout_detector_en = gp_reg[0];
  // RULE_17 brownout reset enable
  assign brownout_reset_en    = gp_reg[1];
  // RULE_20 programming port enabled by straps
  assign fast_programming_port_en = pm_lvl_reg;
  // RULE_09 interrupt on end or error
  assign ctrl_irq = (irqen_reg[0] & done_reg)
                  | (irqen_reg[1] & (lockerr_reg | cmderr_reg));
  assign wait_states = ws_reg;

  // RULE_09 locked program aborts
  a_lock_abort: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_09
    wr_cmd && cmd_op == FPR_OP_PROG && lock_reg[region_of(cmd_arg)]
    && st_reg != FPR_ST_BUSY |=> lockerr_reg && st_reg != FPR_ST_BUSY)
    else $error("locked program not aborted");
  // RULE_11 erase pin unlocks
  a_erase_unlock: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_11
    er_lvl_reg |=> lock_reg == 8'h00)
    else $error("erase pin left a lock set");
  // RULE_16 RULE_17 erase pin clears both brownout bits
  a_gp_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_16
    er_lvl_reg |=> !brownout_detector_en && !brownout_reset_en)
    else $error("erase pin left brownout enabled");
  // RULE_01 sram alias after remap
  a_remap_sram: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_01
    sys_req.valid && sel_zero && remap_reg |-> sys_decode.sel_sram
    && !sys_decode.sel_flash)
    else $error("sram not at zero after remap");
  // RULE_02 flash alias before remap
  a_boot_flash: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_02
    sys_req.valid && sel_zero && !remap_reg && !sys_refused
    |-> sys_decode.sel_flash)
    else $error("flash not at zero before remap");
  // RULE_12 secure refusal
  a_sec_refuse: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
    sec_reg && sys_from_debug && sys_req.valid |-> !sys_decode.sel_flash)
    else $error("secure flash reached from debug");
  // RULE_13 security never falls outside erase
  a_sec_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_13
    $fell(sec_reg) |-> $past(op_reg) == FPR_OP_FULLERA)
    else $error("security cleared without full erase");
  // RULE_10 set-lock effect
  a_set_lock: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_10
    wr_cmd && cmd_op == FPR_OP_SETLOCK && st_reg != FPR_ST_BUSY
    && !er_lvl_reg |=> lock_reg[$past(cmd_arg[2:0])])
    else $error("set-lock had no effect");
  // RULE_21 remap sticky
  a_remap_stick: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_21
    remap_reg |=> remap_reg)
    else $error("remap flag fell without reset");
endmodule : fpr_flash_protect
